// file: logic/isra_pkg.sv
// Shared constants and types of the result-access serial slave.
// Assumes one system clock; all users reference items as isra_pkg::name.
package isra_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h0d;
    localparam logic [7:0] CMD_BLK_WR = 8'ha0;
    localparam logic [7:0] CMD_BLK_RD = 8'ha1;
    localparam logic [7:0] CMD_PTR = 8'hb0;
    localparam logic [7:0] STATUS_ADDR = 8'h8f;
    localparam logic [7:0] REAL_HI_ADDR = 8'h94;
    localparam logic [7:0] REAL_LO_ADDR = 8'h95;
    localparam logic [7:0] IMAG_HI_ADDR = 8'h96;
    localparam logic [7:0] IMAG_LO_ADDR = 8'h97;
    localparam int READY_BIT = 1;
    localparam int DONE_BIT = 2;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_WIDTH = 2;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } isra_wr_type;

    typedef struct packed {
        logic signed [15:0] re;
        logic signed [15:0] im;
    } isra_result_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } isra_state_type;

    typedef enum logic [5:0] {
        PH_ADDR = 6'h01,
        PH_CMD = 6'h02,
        PH_PTR = 6'h04,
        PH_DATA = 6'h08,
        PH_CNT = 6'h10,
        PH_BLKW = 6'h20
    } isra_phase_type;
endpackage

// file: logic/isra_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs come from pins outside the system clock domain.
`timescale 1ns/1ps
module isra_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;

    // Idle bus lines are high, so reset to high
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= '1;
            q_out <= '1;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule // isra_sync

// file: logic/isra_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; flags are registered so they can leave the chip directly.
`timescale 1ns/1ps
module isra_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data_out = mem[rp_r];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            wp_r <= wp_r + AW'(push);
            rp_r <= rp_r + AW'(pop);
            cnt_r <= cnt_nxt;
            in_ready_out <= cnt_nxt != (AW+1)'(DEPTH);
            out_valid_out <= cnt_nxt != '0;
        end
    end
endmodule // isra_fifo

// file: logic/isra_slave.sv
// Serial two-wire slave giving a bus master access to status and results.
// Assumes the measurement engine on mclk_in reports events as one-cycle pulses,
// and takes register writes from the FIFO output.
// Contract
// - Point done sets result-ready flag
// - Frequency commands or reset clear result-ready
// - Last point done sets scan-done flag
// - Sweep start or reset clear scan-done
// - Results are 16-bit, upper byte lower address
// - Results kept through reset, valid when ready
// - Slave only, address 0001101
// - Address MSB first, then direction bit
// - Ack by holding data low at ninth clock
// - Eight bits, then ack; data moves while low
// - First write byte is command or register address
// - Single write: address, register, data, all acked
// - Pointer command loads pointer from next byte
// - Block write: command, count, counted data bytes
// - Single read returns byte at pointer
// - Block read: command, count, restart, read
// - Master NACK then stop ends a read
// - No commands taken in read direction
// - Status byte: bit1 ready, bit2 done
`timescale 1ns/1ps
module isra_slave (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic point_done_in,
    input wire logic last_point_in,
    input wire logic freq_cmd_in,
    input wire logic sweep_start_in,
    input wire logic ctrl_reset_in,
    input wire isra_pkg::isra_result_type result_in,
    output logic [7:0] rd_addr_out,
    input wire logic [7:0] rd_data_in,
    output logic [7:0] status_out,
    output logic wr_valid_out,
    output isra_pkg::isra_wr_type wr_out,
    input wire logic wr_ready_in
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] line_s;
    logic scl_q_r;
    logic sda_q_r;
    isra_pkg::isra_state_type state_r;
    isra_pkg::isra_phase_type phase_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic mack_r;
    logic blk_wr_r;
    logic blk_rd_r;
    logic [7:0] cnt_r;
    logic [7:0] ptr_r;
    logic [7:0] reg_addr_r;
    logic ready_r;
    logic done_r;
    isra_pkg::isra_result_type res_r;
    logic fifo_ready;
    logic push_r;
    isra_pkg::isra_wr_type push_data_r;

    isra_sync #(
        .WIDTH(isra_pkg::SYNC_WIDTH)
    ) u_sync (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .d_in({scl_in, sda_in}),
        .q_out(line_s)
    );

    wire scl_s = line_s[1];
    wire sda_s = line_s[0];
    wire scl_rise = scl_s && !scl_q_r;
    wire scl_fall = !scl_s && scl_q_r;
    // Data moving while clock high marks start/stop
    wire bus_start = scl_s && scl_q_r && sda_q_r && !sda_s;
    wire bus_stop = scl_s && scl_q_r && !sda_q_r && sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // Byte completion and decode
    wire rx_done = (state_r == isra_pkg::ST_RX) && scl_fall && (bit_cnt_r == isra_pkg::BYTE_BITS);
    wire addr_match = shift_r[7:1] == isra_pkg::SLAVE_ADDR;
    wire in_addr = phase_r == isra_pkg::PH_ADDR;
    wire in_blkw = phase_r == isra_pkg::PH_BLKW;
    wire in_data = phase_r == isra_pkg::PH_DATA;
    // Full FIFO or spent count refuses the byte with a NACK
    wire wr_ok = fifo_ready && !push_r && (in_data || cnt_r != 8'h00);
    wire do_push = rx_done && (in_data || in_blkw) && wr_ok;
    wire do_ack = rx_done && (in_addr ? addr_match : ((in_data || in_blkw) ? wr_ok : 1'b1));
    wire tx_load = scl_fall && ((state_r == isra_pkg::ST_ACK && rw_r) || (state_r == isra_pkg::ST_MACK && mack_r));

    // Read mux over the pointer
    wire [7:0] stat_byte = {5'h00, done_r, ready_r, 1'b0};
    wire [7:0] rd_byte = (ptr_r == isra_pkg::STATUS_ADDR) ? stat_byte :
        (ptr_r == isra_pkg::REAL_HI_ADDR) ? res_r.re[15:8] :
        (ptr_r == isra_pkg::REAL_LO_ADDR) ? res_r.re[7:0] :
        (ptr_r == isra_pkg::IMAG_HI_ADDR) ? res_r.im[15:8] :
        (ptr_r == isra_pkg::IMAG_LO_ADDR) ? res_r.im[7:0] : rd_data_in;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // Bus state machine
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_r <= isra_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            sda_oe_out <= 1'b0;
            mack_r <= 1'b0;
        end else if (bus_start) begin
            state_r <= isra_pkg::ST_RX;
            bit_cnt_r <= 4'h0;
            sda_oe_out <= 1'b0;
        end else if (bus_stop) begin
            state_r <= isra_pkg::ST_IDLE;
            sda_oe_out <= 1'b0;
        end else begin
            unique case (state_r)
                isra_pkg::ST_IDLE: begin
                    sda_oe_out <= 1'b0;
                end
                isra_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (rx_done) begin
                        // Drive ack only in clock low before ninth pulse
                        state_r <= do_ack ? isra_pkg::ST_ACK : isra_pkg::ST_IDLE;
                        sda_oe_out <= do_ack;
                    end
                end
                isra_pkg::ST_ACK: begin
                    if (tx_load) begin
                        state_r <= isra_pkg::ST_TX;
                        tx_r <= rd_byte;
                        sda_oe_out <= !rd_byte[7];
                        bit_cnt_r <= 4'h0;
                    end else if (scl_fall) begin
                        state_r <= isra_pkg::ST_RX;
                        sda_oe_out <= 1'b0;
                        bit_cnt_r <= 4'h0;
                    end
                end
                isra_pkg::ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        tx_r <= {tx_r[6:0], 1'b0};
                        if (bit_cnt_r == isra_pkg::LAST_TX_BIT) begin
                            state_r <= isra_pkg::ST_MACK;
                            sda_oe_out <= 1'b0;
                        end else begin
                            sda_oe_out <= !tx_r[6];
                        end
                    end
                end
                isra_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        mack_r <= !sda_s;
                    end else if (tx_load) begin
                        state_r <= isra_pkg::ST_TX;
                        tx_r <= rd_byte;
                        sda_oe_out <= !rd_byte[7];
                        bit_cnt_r <= 4'h0;
                    end else if (scl_fall) begin
                        // Master NACK ends the read; wait for stop
                        state_r <= isra_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transaction phase, pointer and counts; only write bytes decode
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            phase_r <= isra_pkg::PH_ADDR;
            rw_r <= 1'b0;
            blk_wr_r <= 1'b0;
            blk_rd_r <= 1'b0;
            cnt_r <= 8'h00;
            ptr_r <= isra_pkg::PTR_RESET;
            reg_addr_r <= 8'h00;
            push_r <= 1'b0;
            push_data_r <= '0;
        end else begin
            push_r <= do_push;
            if (bus_start) begin
                phase_r <= isra_pkg::PH_ADDR;
            end else if (bus_stop) begin
                blk_rd_r <= 1'b0;
            end else if (rx_done && do_ack) begin
                unique case (phase_r)
                    isra_pkg::PH_ADDR: begin
                        rw_r <= shift_r[0];
                        phase_r <= isra_pkg::PH_CMD;
                    end
                    isra_pkg::PH_CMD: begin
                        if (shift_r == isra_pkg::CMD_PTR) begin
                            phase_r <= isra_pkg::PH_PTR;
                        end else if (shift_r == isra_pkg::CMD_BLK_WR || shift_r == isra_pkg::CMD_BLK_RD) begin
                            blk_wr_r <= shift_r == isra_pkg::CMD_BLK_WR;
                            phase_r <= isra_pkg::PH_CNT;
                        end else begin
                            reg_addr_r <= shift_r;
                            phase_r <= isra_pkg::PH_DATA;
                        end
                    end
                    isra_pkg::PH_PTR: begin
                        ptr_r <= shift_r;
                        phase_r <= isra_pkg::PH_CMD;
                    end
                    isra_pkg::PH_DATA: begin
                        push_data_r <= '{addr: reg_addr_r, data: shift_r};
                        phase_r <= isra_pkg::PH_CMD;
                    end
                    isra_pkg::PH_CNT: begin
                        cnt_r <= shift_r;
                        blk_rd_r <= !blk_wr_r && shift_r != 8'h00;
                        phase_r <= blk_wr_r ? isra_pkg::PH_BLKW : isra_pkg::PH_CMD;
                    end
                    isra_pkg::PH_BLKW: begin
                        push_data_r <= '{addr: ptr_r, data: shift_r};
                        ptr_r <= ptr_r + 8'h01;
                        cnt_r <= cnt_r - 8'h01;
                    end
                endcase
            end else if (tx_load && blk_rd_r) begin
                ptr_r <= ptr_r + 8'h01;
                cnt_r <= cnt_r - 8'h01;
                blk_rd_r <= cnt_r != 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags: a set in the clearing cycle wins
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ready_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (point_done_in) begin
                ready_r <= 1'b1;
            end else if (freq_cmd_in || ctrl_reset_in) begin
                ready_r <= 1'b0;
            end
            if (point_done_in && last_point_in) begin
                done_r <= 1'b1;
            end else if (sweep_start_in || ctrl_reset_in) begin
                done_r <= 1'b0;
            end
        end
    end

    // Results deliberately outside reset
    always_ff @(posedge mclk_in) begin
        if (point_done_in) begin
            res_r <= result_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sda_out <= 1'b0;
            status_out <= 8'h00;
            rd_addr_out <= isra_pkg::PTR_RESET;
        end else begin
            sda_out <= 1'b0;
            status_out <= {5'h00, done_r, ready_r, 1'b0};
            rd_addr_out <= ptr_r;
        end
    end

    isra_fifo #(
        .WIDTH($bits(isra_pkg::isra_wr_type)),
        .DEPTH(isra_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(push_r),
        .in_data_in(push_data_r),
        .in_ready_out(fifo_ready),
        .out_valid_out(wr_valid_out),
        .out_data_out(wr_out),
        .out_ready_in(wr_ready_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence seq_addr_byte;
        rx_done && in_addr;
    endsequence

    a_ready_set: assert property (point_done_in |-> ##2 status_out[isra_pkg::READY_BIT])
        else $error("result-ready not set after point done");
    a_ready_clear: assert property (freq_cmd_in && !point_done_in |=> !ready_r)
        else $error("result-ready not cleared by command");
    a_done_set: assert property (point_done_in && last_point_in |=> done_r)
        else $error("scan-done not set after last point");
    a_done_clear: assert property ((sweep_start_in || ctrl_reset_in) && !point_done_in |=> !done_r)
        else $error("scan-done not cleared");
    a_result_hold: assert property (!point_done_in |=> $stable(res_r))
        else $error("result changed without point done");
    a_ack_low: assert property (state_r == isra_pkg::ST_ACK |-> sda_oe_out)
        else $error("ack state without data driven low");
    a_foreign_addr: assert property (seq_addr_byte ##0 !addr_match |=> state_r == isra_pkg::ST_IDLE && !sda_oe_out)
        else $error("foreign address not ignored");
    a_own_addr: assert property (seq_addr_byte ##0 addr_match |=> sda_oe_out ##0 rw_r == $past(shift_r[0]))
        else $error("own address not acknowledged");
    a_ptr_load: assert property (rx_done && phase_r == isra_pkg::PH_PTR |=> ptr_r == $past(shift_r))
        else $error("pointer not loaded");
    a_blk_step: assert property (do_push && in_blkw |=> ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer not advanced in block write");
    a_read_nocmd: assert property (state_r == isra_pkg::ST_TX |=> $stable(phase_r))
        else $error("phase changed during read byte");
    a_ready_rst: assert property (ctrl_reset_in && !point_done_in |=> !ready_r)
        else $error("result-ready not cleared by reset command");
    a_nack_free: assert property (state_r == isra_pkg::ST_MACK |-> !sda_oe_out)
        else $error("data line held during master acknowledge");
endmodule // isra_slave

// file: sim/isra_master_model.sv
// Behavioural two-wire bus master driving clock and data towards the slave.
// Assumes the bench resolves the pulled-up data wire from every pull-down.
`timescale 1ns/1ps
module isra_master_model (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // Extra low-phase cycles to play a slow master
    int lag = 0;

    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // One pulse; data moves only while the clock is low
    task automatic bit_x(input logic b, output logic s);
        tick(1);
        sda_low_out <= !b;
        tick(3 + lag);
        scl_out <= 1'b1;
        tick(2);
        s = sda_in;
        tick(2);
        scl_out <= 1'b0;
    endtask

    // Long low phase so a held acknowledge is gone before the restart
    task automatic start();
        tick(1);
        sda_low_out <= 1'b0;
        tick(7);
        scl_out <= 1'b1;
        tick(4);
        sda_low_out <= 1'b1;
        tick(4);
        scl_out <= 1'b0;
    endtask

    // Clock then idles high until the next frame
    task automatic stop();
        tick(1);
        sda_low_out <= 1'b1;
        tick(3);
        scl_out <= 1'b1;
        tick(4);
        sda_low_out <= 1'b0;
        tick(4);
    endtask

    // Eight bits MSB first, ninth pulse left to the slave
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask

    // Acknowledge unless last; last gets a release
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            v[i] = s;
        end
        bit_x(last, s);
    endtask
endmodule // isra_master_model

// file: sim/tb_i2c_slave_result_access.sv
// Self-checking bench for the result-access serial slave and its write queue.
// Assumes isra_master_model as bus master and a pulled-up data wire.
`timescale 1ns/1ps
module tb_i2c_slave_result_access;
    logic mclk_in = 1'b0;
    logic rst_in;
    logic point_done, last_point, freq_cmd, sweep_start, ctrl_reset, wr_ready;
    isra_pkg::isra_result_type result;
    isra_pkg::isra_wr_type wr;
    logic [7:0] rd_data, rd_addr, status;
    logic sda_out, sda_oe, wr_valid, scl, m_low, ack;
    logic [7:0] rx [$];
    wire logic sda;
    int miscompares = 0;
    int total_checks = 0;

    assign sda = !(m_low || (sda_oe && !sda_out));

    initial forever #20 mclk_in = ~mclk_in;

    isra_slave isra_slave_i (.mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .point_done_in(point_done),
        .last_point_in(last_point), .freq_cmd_in(freq_cmd), .sweep_start_in(sweep_start),
        .ctrl_reset_in(ctrl_reset), .result_in(result), .rd_addr_out(rd_addr),
        .rd_data_in(rd_data), .status_out(status), .wr_valid_out(wr_valid), .wr_out(wr),
        .wr_ready_in(wr_ready));

    isra_master_model isra_master_model_i (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl),
        .sda_low_out(m_low));

    // Registers outside the slave answer with the inverted pointer
    always @(posedge mclk_in) rd_data <= ~rd_addr;

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        isra_master_model_i.wbyte(b, ack);
        check("ack", 16'(ack), 16'(exp_ack));
    endtask

    task automatic set_ptr(input logic [7:0] p);
        isra_master_model_i.start();
        send(8'h1a, 1'b1);
        send(8'hb0, 1'b1);
        send(p, 1'b1);
        isra_master_model_i.stop();
    endtask

    // Block form writes the command and count first, then restarts
    task automatic rd(input logic [7:0] n, input logic blk);
        logic [7:0] v;
        rx.delete();
        if (blk) begin
            isra_master_model_i.start();
            send(8'h1a, 1'b1);
            send(8'ha1, 1'b1);
            send(n, 1'b1);
        end
        isra_master_model_i.start();
        send(8'h1b, 1'b1);
        for (int i = 0; i < n; i++) begin
            isra_master_model_i.rbyte(i == n - 1, v);
            rx.push_back(v);
        end
        isra_master_model_i.stop();
    endtask

    // Event bits: point done, last point, frequency, sweep start, reset
    task automatic ev(input logic [4:0] m);
        @(posedge mclk_in);
        {point_done, last_point, freq_cmd, sweep_start, ctrl_reset} <= m;
        @(posedge mclk_in);
        {point_done, last_point, freq_cmd, sweep_start, ctrl_reset} <= 5'h00;
        repeat (3) @(posedge mclk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        check("status", 16'(status), 16'h0000);
        check("pointer", 16'(rd_addr), 16'h0000);
        check("sda_oe", 16'(sda_oe), 16'h0000);
        check("sda_out", 16'(sda_out), 16'h0000);
        check("wr_valid", 16'(wr_valid), 16'h0000);
    endtask

    task automatic s_foreign();
        isra_master_model_i.start();
        send(8'h1c, 1'b0);
        send(8'hb0, 1'b0);
        send(8'h55, 1'b0);
        isra_master_model_i.stop();
        check("pointer", 16'(rd_addr), 16'h0000);
    endtask

    task automatic s_single();
        isra_master_model_i.lag = 4;
        isra_master_model_i.start();
        send(8'h1a, 1'b1);
        send(8'h85, 1'b1);
        send(8'h3d, 1'b1);
        isra_master_model_i.stop();
        isra_master_model_i.lag = 0;
        for (int i = 0; i < 100 && wr_valid !== 1'b1; i++) @(posedge mclk_in);
        check("wr_valid", 16'(wr_valid), 16'h0001);
        check("wr_out", wr, 16'h853d);
        wr_ready <= 1'b1;
        @(posedge mclk_in);
        wr_ready <= 1'b0;
        repeat (2) @(posedge mclk_in);
        check("wr_valid", 16'(wr_valid), 16'h0000);
    endtask

    task automatic s_flags();
        result <= {16'h8123, 16'h7ffe};
        ev(5'b10000);
        check("status", 16'(status), 16'h0002);
        ev(5'b00100);
        check("status", 16'(status), 16'h0000);
        ev(5'b11000);
        check("status", 16'(status), 16'h0006);
        set_ptr(isra_pkg::STATUS_ADDR);
        rd(8'h01, 1'b0);
        check("status_rd", 16'(rx[0]), 16'h0006);
        for (int k = 0; k < 2; k++) begin
            set_ptr(isra_pkg::REAL_HI_ADDR);
            rd(8'h04, 1'b1);
            check("real", {rx[0], rx[1]}, 16'h8123);
            check("imag", {rx[2], rx[3]}, 16'h7ffe);
            check("pointer", 16'(rd_addr), 16'h0098);
            ev(5'b00010);
            check("status", 16'(status), 16'(k ? 0 : 2));
            ev(5'b00001);
            check("status", 16'(status), 16'h0000);
            result <= {16'h1111, 16'h2222};
        end
    endtask

    task automatic s_other();
        set_ptr(8'h10);
        rd(8'h01, 1'b0);
        check("rd_byte", 16'(rx[0]), 16'h00ef);
        check("pointer", 16'(rd_addr), 16'h0010);
    endtask

    // Fill the queue past full while the consumer stalls, then drain
    task automatic s_fifo();
        int k;
        k = 0;
        set_ptr(8'h80);
        isra_master_model_i.start();
        send(8'h1a, 1'b1);
        send(8'ha0, 1'b1);
        send(8'h11, 1'b1);
        for (int i = 0; i < 17; i++) send(8'h40 + 8'(i), i < 16);
        isra_master_model_i.stop();
        for (int n = 0; n < 300 && k < 16; n++) begin
            @(posedge mclk_in);
            if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
                check("drain", wr, {8'h80 + 8'(k), 8'h40 + 8'(k)});
                k++;
            end
            wr_ready <= (n % 3 != 0);
        end
        check("drained", 16'(k), 16'h0010);
        @(posedge mclk_in);
        wr_ready <= 1'b0;
        repeat (2) @(posedge mclk_in);
        check("wr_valid", 16'(wr_valid), 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge mclk_in);
        miscompares++;
        conclude();
    end

    initial begin
        rst_in = 1'b1;
        wr_ready = 1'b0;
        {point_done, last_point, freq_cmd, sweep_start, ctrl_reset} = 5'h00;
        result = 32'h0;
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        s_reset();
        s_foreign();
        s_single();
        s_flags();
        s_other();
        s_fifo();
        conclude();
    end
endmodule // tb_i2c_slave_result_access
